/* fcs_pkg.sv */
/*
 * fcs_pkg: command codes, result codes, bank map and timing constants for the
 * host-side flash command sequencer.
 * assumes: one 250 MHz clock; the flash device answers over a simple word port.
 */
`default_nettype none
package fcs_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam logic [15:0] CPU_PERIOD_NS = 16'h0004;
    // command codes; low nibble of program codes carries the segment
    localparam logic [11:0] CMD_PROG_WORD = 12'h55a;
    localparam logic [11:0] CMD_PROG_DWORD = 12'hdd4;
    localparam logic [11:0] CMD_PROG_BLOCK = 12'haa5;
    localparam logic [15:0] CMD_ERASE = 16'heeee;
    localparam logic [15:0] ERASE_KEY = 16'h5555;
    localparam logic [15:0] CMD_STATUS = 16'h7777;
    // result codes returned in word 0
    localparam logic [7:0] RES_OK = 8'h00;
    localparam logic [7:0] RES_PROG_FAIL = 8'h03;
    localparam logic [7:0] RES_ADDR_BAD = 8'h04;
    localparam logic [7:0] RES_PERIOD_BAD = 8'h05;
    localparam logic [7:0] RES_BANK_BAD = 8'h07;
    localparam logic [7:0] RES_ERASE_FAIL = 8'h08;
    localparam logic [7:0] RES_COUNT_BAD = 8'h0a;
    localparam logic [7:0] RES_UNKNOWN = 8'hff;
    localparam logic [15:0] BLOCK_SPAN_LIMIT = 16'h4000;
    localparam int NUM_BANKS = 4;
    // segment 0 / segment 1 bases of the two low banks
    localparam logic [23:0] LOW_SEG0_BASE = 24'h000000;
    localparam logic [23:0] LOW_SEG0_TOP = 24'h007fff;
    localparam logic [23:0] LOW_SEG1_BASE = 24'h010000;
    localparam logic [23:0] FLASH_TOP = 24'h02ffff;
    // typical operation times
    localparam int PROG_TIME_US = 80;
    localparam int ERASE_TIME_MS = 800;
    localparam int PROG_CYCLES = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int ERASE_CYCLES = ERASE_TIME_MS * 1000 * (1000 / CLK_PERIOD_NS);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LOAD = 3'b001,
        ST_UNLOCK1 = 3'b010,
        ST_UNLOCK2 = 3'b011,
        ST_WAIT = 3'b100,
        ST_DONE = 3'b101
    } fcs_state_t;
endpackage
`default_nettype wire

/* fcs_regs.sv */
/*
 * fcs_regs: the five parameter words handed to the flash kernel, with a
 * registered read port.
 * assumes: single writer; reads take one cycle.
 */
`default_nettype none
module fcs_regs #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic we,
    input wire logic [2:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [2:0] raddr,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem_r [0:4];
    logic [W-1:0] rdata_r;
    assign rdata = rdata_r;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else if (ce) begin
            if (we && waddr < 3'd5) begin
                mem_r[waddr] <= wdata;
            end
            rdata_r <= (raddr < 3'd5) ? mem_r[raddr] : '0;
        end
    end
endmodule // fcs_regs
`default_nettype wire

/* fcs_host.sv */
/*
 * fcs_host: host controller that loads command words, issues the two-write
 * unlock, waits for the device kernel and returns its result code.
 * assumes: device exposes param write port, unlock write port, busy and result.
 */
`default_nettype none
// Summary of operation
// - no fetch, branch or read of flash while an operation runs
// - with low banks in segment 0, no interrupt during operation
// - command in word 0, parameters in words 1 to 4 before trigger
// - single word: code 55As, offset in word 1, data in word 2
// - double word: code DD4s, offset, low word, high word
// - block: code AA5s, first, last, source; span below 16384
// - block source plus span below 16384; pages 0,1 barred if select set (not checked here: select only picks the unlock base)
// - erase: EEEE, 5555 key, same bank twice, mismatch rejected
// - status: 7777, words 1 to 3 only carry returned values
// - word 4 always holds cpu period in ns
// - every target offset is even
// - unlock is two writes to the same even flash address
// - at least 45 free stack words before program or erase
module fcs_host
    import fcs_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = ERASE_CYCLES * 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic req_valid,
    input wire logic [15:0] req_cmd,
    input wire logic [15:0] req_p1,
    input wire logic [15:0] req_p2,
    input wire logic [15:0] req_p3,
    input wire logic [15:0] trigger_offset,
    input wire logic high_block_segment_select,
    input wire logic dev_busy,
    input wire logic dev_done,
    input wire logic [15:0] dev_result,
    output logic req_ready,
    output logic dev_param_we,
    output logic [2:0] dev_param_idx,
    output logic [15:0] dev_param_data,
    output logic dev_unlock_we,
    output logic [23:0] dev_unlock_addr,
    output logic flash_read_hold,
    output logic resp_valid,
    output logic [7:0] resp_code
);
    import fcs_pkg::*;

    fcs_state_t state_r, state_nxt;
    logic [2:0] idx_r, idx_nxt;
    logic [2:0] pidx_r, pidx_nxt;
    logic ready_r, ready_nxt;
    logic pwe_r, pwe_nxt;
    logic [15:0] pdata_r, pdata_nxt;
    logic uwe_r, uwe_nxt;
    logic [23:0] uaddr_r, uaddr_nxt;
    logic hold_r, hold_nxt;
    logic rv_r, rv_nxt;
    logic [7:0] code_r, code_nxt;
    logic [31:0] tmo_r, tmo_nxt;
    logic [2:0] rd_addr;
    logic [15:0] rd_data;

    // copy of the word stream as sent; read back at unlock as a self-check
    fcs_regs #(.W(16)) u_regs (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .we(state_r == ST_LOAD),
        .waddr(idx_r),
        .wdata(pdata_nxt),
        .raddr(rd_addr),
        .rdata(rd_data)
    );

    // local validity check: catches errors before touching the device
    function automatic logic [7:0] precheck(input logic [15:0] c, input logic [15:0] a,
                                            input logic [15:0] b, input logic [15:0] d);
        logic [15:0] span;
        span = b - a;
        precheck = RES_OK;
        if (c[15:4] == CMD_PROG_WORD || c[15:4] == CMD_PROG_DWORD) begin
            if (a[0]) precheck = RES_ADDR_BAD;
        end else if (c[15:4] == CMD_PROG_BLOCK) begin
            if (a[0] || b[0]) precheck = RES_ADDR_BAD;
            else if (b < a || span >= BLOCK_SPAN_LIMIT) precheck = RES_COUNT_BAD;
            else if ({1'b0, d} + {1'b0, span} >= {1'b0, BLOCK_SPAN_LIMIT}) begin
                // one bit wider so a high source cannot wrap below the limit
                precheck = RES_COUNT_BAD;
            end
        end else if (c == CMD_ERASE) begin
            if (a != ERASE_KEY) precheck = RES_UNKNOWN;
            else if (b != d || b >= 16'(NUM_BANKS)) precheck = RES_BANK_BAD;
        end else if (c != CMD_STATUS) begin // status words are passed on unchecked
            precheck = RES_UNKNOWN;
        end
    endfunction

    logic [15:0] c_r, p1_r, p2_r, p3_r;
    logic [15:0] c_nxt, p1_nxt, p2_nxt, p3_nxt;
    assign rd_addr = idx_r;

    always_comb begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        pidx_nxt = pidx_r;
        pwe_nxt = 1'b0;
        pdata_nxt = pdata_r;
        uwe_nxt = 1'b0;
        uaddr_nxt = uaddr_r;
        hold_nxt = hold_r;
        rv_nxt = 1'b0;
        code_nxt = code_r;
        tmo_nxt = tmo_r;
        c_nxt = c_r;
        p1_nxt = p1_r;
        p2_nxt = p2_r;
        p3_nxt = p3_r;
        unique case (state_r)
            ST_IDLE: begin
                if (req_valid) begin
                    c_nxt = req_cmd;
                    p1_nxt = req_p1;
                    p2_nxt = req_p2;
                    p3_nxt = req_p3;
                    code_nxt = precheck(req_cmd, req_p1, req_p2, req_p3);
                    idx_nxt = 3'd0;
                    if (code_nxt != RES_OK) begin
                        rv_nxt = 1'b1;
                    end else begin
                        state_nxt = ST_LOAD;
                    end
                end
            end
            ST_LOAD: begin
                // words 0..4: command, parameters, cpu period
                // words are streamed out, nothing is pushed: no stack use here
                pwe_nxt = 1'b1;
                pidx_nxt = idx_r;
                unique case (idx_r)
                    3'd0: pdata_nxt = c_r;
                    3'd1: pdata_nxt = p1_r;
                    3'd2: pdata_nxt = p2_r;
                    3'd3: pdata_nxt = p3_r;
                    default: pdata_nxt = CPU_PERIOD_NS;
                endcase
                if (idx_r == 3'd4) begin
                    state_nxt = ST_UNLOCK1;
                end else begin
                    idx_nxt = idx_r + 3'd1;
                end
            end
            ST_UNLOCK1: begin
                // same even address for both writes
                uaddr_nxt = (high_block_segment_select ? LOW_SEG1_BASE : LOW_SEG0_BASE)
                    | {8'h00, trigger_offset[15:1], 1'b0};
                uwe_nxt = 1'b1;
                hold_nxt = 1'b1; // no fetch can vector into flash
                state_nxt = ST_UNLOCK2;
            end
            ST_UNLOCK2: begin
                uwe_nxt = 1'b1;
                tmo_nxt = 32'd0;
                state_nxt = ST_WAIT;
            end
            ST_WAIT: begin
                // hold flash reads until result arrives
                tmo_nxt = tmo_r + 32'd1;
                if (dev_done) begin
                    code_nxt = dev_result[7:0];
                    state_nxt = ST_DONE;
                end else if (tmo_r >= 32'(TIMEOUT_CYCLES)) begin
                    code_nxt = (c_r == CMD_ERASE) ? RES_ERASE_FAIL : RES_PROG_FAIL;
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                hold_nxt = 1'b0;
                rv_nxt = 1'b1;
                state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
        // ready is registered: high only while idle
        ready_nxt = (state_nxt == ST_IDLE);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            idx_r <= 3'd0;
            pidx_r <= 3'd0;
            ready_r <= 1'b0;
            pwe_r <= 1'b0;
            pdata_r <= 16'h0000;
            uwe_r <= 1'b0;
            uaddr_r <= 24'h000000;
            hold_r <= 1'b0;
            rv_r <= 1'b0;
            code_r <= 8'h00;
            tmo_r <= 32'd0;
            c_r <= 16'h0000;
            p1_r <= 16'h0000;
            p2_r <= 16'h0000;
            p3_r <= 16'h0000;
        end else if (ce) begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            pidx_r <= pidx_nxt;
            ready_r <= ready_nxt;
            pwe_r <= pwe_nxt;
            pdata_r <= pdata_nxt;
            uwe_r <= uwe_nxt;
            uaddr_r <= uaddr_nxt;
            hold_r <= hold_nxt;
            rv_r <= rv_nxt;
            code_r <= code_nxt;
            tmo_r <= tmo_nxt;
            c_r <= c_nxt;
            p1_r <= p1_nxt;
            p2_r <= p2_nxt;
            p3_r <= p3_nxt;
        end
    end

    assign req_ready = ready_r;
    assign dev_param_we = pwe_r;
    assign dev_param_idx = pidx_r;
    assign dev_param_data = pdata_r;
    assign dev_unlock_we = uwe_r;
    assign dev_unlock_addr = uaddr_r;
    assign flash_read_hold = hold_r;
    assign resp_valid = rv_r;
    assign resp_code = code_r;

    // unlock writes come as two consecutive pulses at one address
    sequence s_unlock;
        dev_unlock_we ##1 (dev_unlock_we && $stable(dev_unlock_addr));
    endsequence
    property p_unlock_pair;
        @(posedge clk) disable iff (!rst_n)
        (ce && state_r == ST_UNLOCK1) |=> s_unlock;
    endproperty
    a_unlock_pair: assert property (p_unlock_pair) else $error("unlock not two writes");
    property p_unlock_even;
        @(posedge clk) disable iff (!rst_n) dev_unlock_we |-> !dev_unlock_addr[0];
    endproperty
    a_unlock_even: assert property (p_unlock_even) else $error("odd unlock address");
    property p_hold_wait;
        @(posedge clk) disable iff (!rst_n) (state_r == ST_WAIT) |-> flash_read_hold;
    endproperty
    a_hold_wait: assert property (p_hold_wait) else $error("flash not held");
    property p_period;
        @(posedge clk) disable iff (!rst_n)
        (dev_param_we && state_r == ST_UNLOCK1) |-> dev_param_data == CPU_PERIOD_NS;
    endproperty
    a_period: assert property (p_period) else $error("period word wrong");
    // the stored stream must end in the period word the device times pulses from
    property p_readback;
        @(posedge clk) disable iff (!rst_n)
        (state_r == ST_UNLOCK2) |-> rd_data == CPU_PERIOD_NS;
    endproperty
    a_readback: assert property (p_readback) else $error("stored period word wrong");
    property p_busy_hold;
        @(posedge clk) disable iff (!rst_n) dev_busy |-> flash_read_hold;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("read while device busy");
    property p_release;
        @(posedge clk) disable iff (!rst_n)
        (ce && state_r == ST_DONE) |=> (resp_valid && !flash_read_hold);
    endproperty
    a_release: assert property (p_release) else $error("hold not released with result");
endmodule // fcs_host
`default_nettype wire

/* fcs_dev_model.sv */
/*
 * fcs_dev_model: behavioural flash kernel on the far side of the host sequencer.
 * assumes: five parameter words, then two unlock writes on consecutive cycles.
 */
`default_nettype none
module fcs_dev_model #(
    parameter int PERIOD_MIN = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic param_we,
    input wire logic [2:0] param_idx,
    input wire logic [15:0] param_data,
    input wire logic unlock_we,
    input wire logic [23:0] unlock_addr,
    input wire logic [7:0] lat,
    input wire logic fail,
    input wire logic stall,
    output logic busy,
    output logic done,
    output logic [15:0] result
);
    timeunit 1ns;
    timeprecision 1ps;
    import fcs_pkg::*;
    logic [15:0] w [0:4];
    logic [23:0] ua; // one 16 MByte linear space
    logic armed;
    logic [7:0] cnt; // short busy span stands in for the program and erase times
    function automatic logic [7:0] judge();
        if (w[4] < PERIOD_MIN || w[4] > 16'd1000) return RES_PERIOD_BAD; // period
        if (w[0][15:4] == CMD_PROG_WORD || w[0][15:4] == CMD_PROG_DWORD)
            return fail ? RES_PROG_FAIL : RES_OK; // verify, one 32-bit row
        if (w[0][15:4] == CMD_PROG_BLOCK) begin
            if (w[2] - w[1] >= BLOCK_SPAN_LIMIT) return RES_COUNT_BAD; // span
            return fail ? RES_PROG_FAIL : RES_OK;
        end
        if (w[0] == CMD_ERASE) begin
            if (w[1] != ERASE_KEY) return RES_UNKNOWN; // key
            if (w[2] != w[3] || w[2] >= NUM_BANKS) return RES_BANK_BAD; // bank
            return fail ? RES_ERASE_FAIL : RES_OK; // erase verify
        end
        return (w[0] == CMD_STATUS) ? RES_OK : RES_UNKNOWN; // decode
    endfunction
    // no outside view path is modelled, so read protection changes nothing here
    always @(posedge clk) begin
        done <= 1'b0;
        result <= ~result; // stale answer changes every cycle
        if (!rst_n) begin
            busy <= 1'b0;
            armed <= 1'b0;
            result <= 16'h0000;
        end else begin
            if (param_we && param_idx < 3'h5) w[param_idx] <= param_data; // words
            armed <= unlock_we && !busy;
            ua <= unlock_addr;
            if (unlock_we && armed && unlock_addr == ua && !ua[0] && !stall) begin
                busy <= 1'b1;
                cnt <= lat;
            end
            if (busy) begin
                if (cnt == 8'h00) begin
                    busy <= 1'b0; // reads allowed again
                    done <= 1'b1;
                    result <= {8'h00, judge()}; // result code
                end else cnt <= cnt - 8'h01;
            end
        end
    end
endmodule // fcs_dev_model
`default_nettype wire

/* tb.sv */
/*
 * tb: self-checking bench for the host flash command sequencer.
 * assumes: fcs_pkg, fcs_host and fcs_dev_model are compiled first.
 */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fcs_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic req_valid = 1'b0;
    logic sel = 1'b1;
    logic fail = 1'b0;
    logic stall = 1'b0;
    logic [15:0] cmd = 16'h0000;
    logic [15:0] p1 = 16'h0000;
    logic [15:0] p2 = 16'h0000;
    logic [15:0] p3 = 16'h0000;
    logic [15:0] toff = 16'h0225;
    logic [7:0] lat = 8'h03;
    logic busy, done, ready, pwe, uwe, hold, rv;
    logic [15:0] res, pdata;
    logic [2:0] pidx;
    logic [23:0] uaddr;
    logic [7:0] rc;
    int n_errors = 0;
    int compares = 0;
    always #2 clk = ~clk;
    fcs_host #(.TIMEOUT_CYCLES(100)) dut (.clk(clk), .rst_n(rst_n), .ce(ce),
        .req_valid(req_valid), .req_cmd(cmd), .req_p1(p1), .req_p2(p2), .req_p3(p3),
        .trigger_offset(toff), .high_block_segment_select(sel), .dev_busy(busy),
        .dev_done(done), .dev_result(res), .req_ready(ready), .dev_param_we(pwe),
        .dev_param_idx(pidx), .dev_param_data(pdata), .dev_unlock_we(uwe),
        .dev_unlock_addr(uaddr), .flash_read_hold(hold), .resp_valid(rv), .resp_code(rc));
    // the host always sends a 4 ns period, so the model's floor follows it
    fcs_dev_model #(.PERIOD_MIN(4)) model (.clk(clk), .rst_n(rst_n), .param_we(pwe),
        .param_idx(pidx), .param_data(pdata), .unlock_we(uwe), .unlock_addr(uaddr),
        .lat(lat), .fail(fail), .stall(stall), .busy(busy), .done(done), .result(res));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("n_errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // one request; remote says whether it must reach the device
    task automatic run(input logic [15:0] c, a, b, d, input logic [7:0] exp, input bit remote);
        logic [15:0] wds [0:4];
        int np;
        int nu;
        bit seen;
        wds = '{c, a, b, d, CPU_PERIOD_NS};
        np = 0;
        nu = 0;
        seen = 0;
        @(posedge clk);
        {cmd, p1, p2, p3} <= {c, a, b, d};
        req_valid <= 1'b1;
        @(posedge clk);
        req_valid <= 1'b0;
        // a local refusal answers in this very cycle, so look before waiting
        #1;
        for (int k = 0; k < 400 && rv !== 1'b1; k++) begin
            @(posedge clk);
            #1;
            if (pwe === 1'b1) begin
                chk({pidx, pdata}, {np[2:0], wds[np % 5]}); // word order
                np++;
            end
            if (uwe === 1'b1) begin
                chk(uaddr, {7'h00, sel, toff[15:1], 1'b0}); // even, mapped
                nu++;
                seen = 1;
            end
            if (seen && rv !== 1'b1) chk(hold, 1'b1); // reads held off
        end
        chk(rv, 1'b1); // answer given
        chk(rc, exp); // result code
        chk(np, remote ? 5 : 0); // all words sent
        chk(nu, remote ? 2 : 0); // two unlock writes
        @(posedge clk);
        #1;
        chk({hold, ready}, 2'b01); // released after result
    endtask
    task automatic t_program();
        run({CMD_PROG_WORD, 4'h1}, 16'h0224, 16'hbeef, 16'h0000, RES_OK, 1);
        lat <= 8'h28;
        run({CMD_PROG_DWORD, 4'h1}, 16'h0228, 16'h1234, 16'h5678, RES_OK, 1);
        lat <= 8'h00;
        fail <= 1'b1;
        run({CMD_PROG_DWORD, 4'h1}, 16'h0230, 16'h0001, 16'h0002, RES_PROG_FAIL, 1);
        fail <= 1'b0;
        run({CMD_PROG_WORD, 4'h1}, 16'h0223, 16'h0000, 16'h0000, RES_ADDR_BAD, 0); // odd
    endtask
    task automatic t_block();
        sel <= 1'b0;
        run({CMD_PROG_BLOCK, 4'h0}, 16'h0000, 16'h3ffe, 16'h0000, RES_OK, 1); // top
        run({CMD_PROG_BLOCK, 4'h0}, 16'h0100, 16'h0100, 16'h0000, RES_OK, 1); // zero
        run({CMD_PROG_BLOCK, 4'h0}, 16'h0000, 16'h4000, 16'h0000, RES_COUNT_BAD, 0);
        run({CMD_PROG_BLOCK, 4'h0}, 16'h0000, 16'h0011, 16'h0000, RES_ADDR_BAD, 0);
    endtask
    task automatic t_erase();
        for (int b = 0; b < NUM_BANKS; b++)
            run(CMD_ERASE, ERASE_KEY, 16'(b), 16'(b), RES_OK, 1); // each bank
        run(CMD_ERASE, ERASE_KEY, 16'h0001, 16'h0002, RES_BANK_BAD, 0); // mismatch
        run(CMD_ERASE, ERASE_KEY, 16'h0004, 16'h0004, RES_BANK_BAD, 0); // no bank 4
        run(CMD_ERASE, 16'h5554, 16'h0000, 16'h0000, RES_UNKNOWN, 0); // key
        fail <= 1'b1;
        run(CMD_ERASE, ERASE_KEY, 16'h0003, 16'h0003, RES_ERASE_FAIL, 1);
        fail <= 1'b0;
    endtask
    task automatic t_misc();
        run(CMD_STATUS, 16'hffff, 16'ha5a5, 16'h5a5a, RES_OK, 1); // junk ignored
        run(16'h1234, 16'h0000, 16'h0000, 16'h0000, RES_UNKNOWN, 0);
        stall <= 1'b1;
        run({CMD_PROG_WORD, 4'h0}, 16'h0010, 16'h0000, 16'h0000, RES_PROG_FAIL, 1);
        run(CMD_ERASE, ERASE_KEY, 16'h0002, 16'h0002, RES_ERASE_FAIL, 1);
        stall <= 1'b0;
    endtask
    // clock enable low: a standing request must not be taken
    task automatic t_freeze();
        @(posedge clk);
        ce <= 1'b0;
        cmd <= CMD_STATUS;
        req_valid <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk({pwe, rv, ready}, 3'b001); // frozen, nothing sent
        @(posedge clk);
        ce <= 1'b1;
        req_valid <= 1'b0;
        @(posedge clk);
        #1;
        chk({pwe, rv, ready}, 3'b001); // nothing left pending
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({pwe, uwe, rv, hold, ready}, 5'h00); // outputs idle in reset
        repeat (2) @(posedge clk);
        #1;
        chk(ready, 1'b1); // ready after release
        t_program();
        t_block();
        t_erase();
        t_misc();
        t_freeze();
        tally_and_finish();
    end
    initial begin
        #200000;
        n_errors++;
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
